// file: cci_inquiry_regs.sv
// Purpose: read-only capability inquiry bank of the camera
// Assumes: host quadlet reads arrive as one request at a time
// Notes: capability values are fixed by parameters at build time
`timescale 1ns/1ps
`default_nettype none
`include "cci_map.svh"

module cci_inquiry_regs #(
    parameter logic ADV_FEATURE_CAP = 1'b1,
    parameter logic VMODE_ERR_CAP = 1'b1,
    parameter logic FEAT_ERR_CAP = 1'b1,
    parameter logic B_MODE_CAP = 1'b0,
    parameter logic POWER_CAP = 1'b1,
    parameter logic ONE_SHOT_CAP = 1'b1,
    parameter logic MULTI_SHOT_CAP = 1'b1,
    parameter logic [3:0] MAX_MEM_CHANNEL = 4'h2,
    parameter logic [15:0] FEAT_HI_CAPS = 16'hffff,
    parameter logic [3:0] FEAT_LO_PTZ_CAPS = 4'h0,
    parameter logic [1:0] FEAT_LO_F6_CAPS = 2'h0,
    parameter logic PARALLEL_IO_CAP = 1'b1,
    parameter logic SERIAL_IO_CAP = 1'b1,
    parameter logic FLASH_OUT_CAP = 1'b1,
    parameter logic [31:0] VENDOR_PTR = 32'h0000_0000,
    parameter logic [31:0] PARALLEL_IO_PTR = 32'h0000_0000,
    parameter logic [31:0] SERIAL_IO_PTR = 32'h0000_0000,
    parameter logic [31:0] FLASH_OUT_PTR = 32'h0000_0000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire cci_pkg::cci_req_t req,
    output logic req_ready,
    output cci_pkg::cci_rsp_t rsp
);

    // ***********************************************************************
    // flag words in msb-first order
    // ***********************************************************************
    logic [31:0] pos_basic;
    logic [31:0] pos_feat_hi;
    logic [31:0] pos_feat_lo;
    logic [31:0] pos_opt;
    logic [127:0] packed_words;
    logic [31:0] q_basic;
    logic [31:0] q_feat_hi;
    logic [31:0] q_feat_lo;
    logic [31:0] q_opt;
    logic optional_block_cap;

    // the optional block exists exactly when one of its functions does
    assign optional_block_cap = PARALLEL_IO_CAP | SERIAL_IO_CAP |
        FLASH_OUT_CAP;

    // basic functions; untouched positions stay reserved zero
    always_comb begin
        pos_basic = 32'h0000_0000;
        pos_basic[`CCI_POS_ADV] = ADV_FEATURE_CAP;
        pos_basic[`CCI_POS_VMODE_ERR] = VMODE_ERR_CAP;
        pos_basic[`CCI_POS_FEAT_ERR] = FEAT_ERR_CAP;
        pos_basic[`CCI_POS_OPT_BLOCK] = optional_block_cap;
        pos_basic[`CCI_POS_B_MODE] = B_MODE_CAP;
        pos_basic[`CCI_POS_POWER] = POWER_CAP;
        pos_basic[`CCI_POS_ONE_SHOT] = ONE_SHOT_CAP;
        pos_basic[`CCI_POS_MULTI_SHOT] = MULTI_SHOT_CAP;
        // channel count is a number: its msb sits at position 28
        for (int k = 0; k < 4; k++) begin
            pos_basic[`CCI_POS_MEM_CH + k] = MAX_MEM_CHANNEL[3-k];
        end
    end

    // feature presence; position i of the parameter is control i
    always_comb begin
        pos_feat_hi = 32'h0000_0000;
        pos_feat_hi[15:0] = FEAT_HI_CAPS;
        pos_feat_lo = 32'h0000_0000;
        pos_feat_lo[3:0] = FEAT_LO_PTZ_CAPS;
        pos_feat_lo[`CCI_POS_F6_SIZE +: 2] = FEAT_LO_F6_CAPS;
        pos_opt = 32'h0000_0000;
        pos_opt[`CCI_POS_PARALLEL] = PARALLEL_IO_CAP;
        pos_opt[`CCI_POS_PARALLEL + 1] = SERIAL_IO_CAP;
        pos_opt[`CCI_POS_PARALLEL + 2] = FLASH_OUT_CAP;
    end

    cci_quadlet_pack #(
        .N_WORDS(4)
    ) u_pack (
        .pos_bits({pos_opt, pos_feat_lo, pos_feat_hi, pos_basic}),
        .quadlets(packed_words)
    );

    assign q_basic = packed_words[31:0];
    assign q_feat_hi = packed_words[63:32];
    assign q_feat_lo = packed_words[95:64];
    assign q_opt = packed_words[127:96];

    // ***********************************************************************
    // address decode
    // ***********************************************************************
    cci_pkg::cci_sel_t sel;
    logic gap;

    cci_addr_decode u_dec (
        .addr(req.addr),
        .sel(sel),
        .gap(gap)
    );

    // ***********************************************************************
    // read mux
    // ***********************************************************************
    logic [31:0] read_word;

    // gap and unmapped offsets fall through to zero
    always_comb begin
        case (sel)
            cci_pkg::CCI_SEL_BASIC: read_word = q_basic;
            cci_pkg::CCI_SEL_FEAT_HI: read_word = q_feat_hi;
            cci_pkg::CCI_SEL_FEAT_LO: read_word = q_feat_lo;
            cci_pkg::CCI_SEL_OPT: read_word = q_opt;
            cci_pkg::CCI_SEL_VENDOR: read_word = VENDOR_PTR;
            cci_pkg::CCI_SEL_PIO: read_word = PARALLEL_IO_PTR;
            cci_pkg::CCI_SEL_SIO: read_word = SERIAL_IO_PTR;
            cci_pkg::CCI_SEL_FLASH: read_word = FLASH_OUT_PTR;
            default: read_word = 32'h0000_0000;
        endcase
    end

    // ***********************************************************************
    // request state
    // ***********************************************************************
    cci_pkg::cci_regs_t regs_ff;
    cci_pkg::cci_regs_t nxt_regs;
    logic accept;

    // one request in flight keeps the answer stable without a buffer
    assign req_ready = (regs_ff.state == cci_pkg::CCI_ST_IDLE);
    assign accept = req.valid && req_ready;

    // writes are answered but store nothing; their data reads zero
    always_comb begin
        nxt_regs = regs_ff;
        case (regs_ff.state)
            cci_pkg::CCI_ST_IDLE: begin
                if (accept) begin
                    nxt_regs.state = cci_pkg::CCI_ST_ANSWER;
                    nxt_regs.hit = (sel != cci_pkg::CCI_SEL_NONE) || gap;
                    nxt_regs.rdata = req.write ? 32'h0000_0000 :
                        read_word;
                end
            end
            cci_pkg::CCI_ST_ANSWER: begin
                nxt_regs.state = cci_pkg::CCI_ST_IDLE;
            end
            default: begin
                nxt_regs.state = cci_pkg::CCI_ST_IDLE;
            end
        endcase
    end

    // registered copy of the whole state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regs_ff.state <= cci_pkg::CCI_ST_IDLE;
            regs_ff.hit <= `CCI_HIT_RST;
            regs_ff.rdata <= `CCI_RDATA_RST;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    // answer outputs straight from the state flops
    assign rsp.valid = (regs_ff.state == cci_pkg::CCI_ST_ANSWER);
    assign rsp.hit = regs_ff.hit;
    assign rsp.data = regs_ff.rdata;

    // ***********************************************************************
    // checks
    // ***********************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // reverse helper for the checks, kept apart from the pack module
    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) begin
            rev16[15 - i] = v[i];
        end
    endfunction

    // a read taken at a given offset
    sequence seq_read_at(logic [`CCI_ADDR_W-1:0] a);
        accept && !req.write && (req.addr == a);
    endsequence

    // a write taken at any offset
    sequence seq_write_taken;
        accept && req.write;
    endsequence

    // answer one cycle later, then idle again
    sequence seq_answer;
        rsp.valid ##1 (!rsp.valid && req_ready);
    endsequence

    // zero answer that is still zero in the idle cycle after it
    sequence seq_zero_answer;
        (rsp.valid && (rsp.data == 32'h0000_0000)) ##1
            (rsp.data == 32'h0000_0000);
    endsequence

    // port behaviour: one request in flight, answer held until the next
    chk_answer_timing: assert property (
        accept |=> seq_answer)
        else $error("answer not given one cycle after request");

    // held data lets a slow host pick the answer up late
    chk_answer_held: assert property (
        !accept |=> $stable(rsp.data) && $stable(rsp.hit))
        else $error("answer changed without a request");

    chk_mapped_hit: assert property (
        accept && (sel != cci_pkg::CCI_SEL_NONE) |=> rsp.hit && rsp.valid)
        else $error("mapped offset not answered as a hit");

    chk_unmapped_miss: assert property (
        accept && (sel == cci_pkg::CCI_SEL_NONE) && !gap |=>
        !rsp.hit && (rsp.data == 32'h0000_0000))
        else $error("unmapped offset answered as a hit");

    chk_write_ignored: assert property (
        seq_write_taken |=> seq_zero_answer)
        else $error("write answered with data");

    chk_gap_zero: assert property (
        accept && gap |=> (rsp.data == 32'h0000_0000) && rsp.hit)
        else $error("reserved window read not zero");

    // basic function word, field by field; position p is data bit 31-p
    chk_basic_low: assert property (
        seq_read_at(`CCI_OFF_BASIC) |=>
        (rsp.data[31:28] == {ADV_FEATURE_CAP, VMODE_ERR_CAP, FEAT_ERR_CAP,
        PARALLEL_IO_CAP | SERIAL_IO_CAP | FLASH_OUT_CAP}) &&
        (rsp.data[27:24] == 4'h0))
        else $error("basic word top nibble wrong");

    chk_basic_mode: assert property (
        seq_read_at(`CCI_OFF_BASIC) |=>
        (rsp.data[23] == B_MODE_CAP) && (rsp.data[15] == POWER_CAP) &&
        (rsp.data[22:16] == 7'h00) && (rsp.data[14:13] == 2'h0))
        else $error("basic word bus or power flag wrong");

    chk_basic_shot: assert property (
        seq_read_at(`CCI_OFF_BASIC) |=>
        (rsp.data[12:11] == {ONE_SHOT_CAP, MULTI_SHOT_CAP}) &&
        (rsp.data[10:4] == 7'h00))
        else $error("basic word shot flags wrong");

    chk_mem_channel: assert property (
        seq_read_at(`CCI_OFF_BASIC) |=>
        rsp.data[3:0] == MAX_MEM_CHANNEL)
        else $error("memory channel count wrong");

    chk_msb_order: assert property (
        seq_read_at(`CCI_OFF_BASIC) |=>
        (rsp.data[31] == ADV_FEATURE_CAP) &&
        (rsp.data[0] == MAX_MEM_CHANNEL[0]))
        else $error("bit order of basic word reversed");

    // feature presence and optional words
    chk_feat_hi: assert property (
        seq_read_at(`CCI_OFF_FEAT_HI) |=>
        (rsp.data[31:16] == rev16(FEAT_HI_CAPS)) &&
        (rsp.data[15:0] == 16'h0000))
        else $error("high feature word wrong");

    chk_shading_delay: assert property (
        seq_read_at(`CCI_OFF_FEAT_HI) |=>
        (rsp.data[17] == FEAT_HI_CAPS[14]) &&
        (rsp.data[18] == FEAT_HI_CAPS[13]))
        else $error("shading or delay flag misplaced");

    chk_feat_lo: assert property (
        seq_read_at(`CCI_OFF_FEAT_LO) |=>
        (rsp.data[31:16] == rev16({12'h000, FEAT_LO_PTZ_CAPS})) &&
        (rsp.data[15:0] == rev16({14'h0000, FEAT_LO_F6_CAPS})))
        else $error("low feature word wrong");

    chk_opt_word: assert property (
        seq_read_at(`CCI_OFF_OPT) |=>
        rsp.data == {1'b0, PARALLEL_IO_CAP, SERIAL_IO_CAP, FLASH_OUT_CAP,
        28'h0000000})
        else $error("optional word wrong");

    chk_flag_values: assert property (
        seq_read_at(`CCI_OFF_OPT) |=>
        ((rsp.data[31] == 1'b0) && (rsp.data[29] == SERIAL_IO_CAP)) ##1
        $stable(rsp.data))
        else $error("reserved optional flag set or answer moved");

    // pointer words return their build-time offsets unchanged
    chk_vendor_ptr: assert property (
        seq_read_at(`CCI_OFF_VENDOR_PTR) |=> rsp.data == VENDOR_PTR)
        else $error("vendor pointer wrong");

    chk_pio_ptr: assert property (
        seq_read_at(`CCI_OFF_PIO_PTR) |=> rsp.data == PARALLEL_IO_PTR)
        else $error("parallel io pointer wrong");

    chk_sio_ptr: assert property (
        seq_read_at(`CCI_OFF_SIO_PTR) |=> rsp.data == SERIAL_IO_PTR)
        else $error("serial io pointer wrong");

    chk_flash_ptr: assert property (
        seq_read_at(`CCI_OFF_FLASH_PTR) |=> rsp.data == FLASH_OUT_PTR)
        else $error("flash output pointer wrong");

endmodule
`default_nettype wire

// file: cci_map.svh
// Purpose: offsets, field positions and reset values of the inquiry bank
// Assumes: byte offsets within the initial register space, quadlet aligned
// Notes: field positions use the bank's own numbering, bit 0 = quadlet msb
`ifndef CCI_MAP_SVH
`define CCI_MAP_SVH

// ***********************************************************************
// address layout
// ***********************************************************************
`define CCI_ADDR_W 12
`define CCI_OFF_BASIC 12'h400
`define CCI_OFF_FEAT_HI 12'h404
`define CCI_OFF_FEAT_LO 12'h408
`define CCI_OFF_OPT 12'h40c
`define CCI_OFF_GAP_LO 12'h410
`define CCI_OFF_GAP_HI 12'h47c
`define CCI_OFF_VENDOR_PTR 12'h480
`define CCI_OFF_PIO_PTR 12'h484
`define CCI_OFF_SIO_PTR 12'h488
`define CCI_OFF_FLASH_PTR 12'h48c

// ***********************************************************************
// field positions, msb-first numbering
// ***********************************************************************
`define CCI_POS_ADV 0
`define CCI_POS_VMODE_ERR 1
`define CCI_POS_FEAT_ERR 2
`define CCI_POS_OPT_BLOCK 3
`define CCI_POS_B_MODE 8
`define CCI_POS_POWER 16
`define CCI_POS_ONE_SHOT 19
`define CCI_POS_MULTI_SHOT 20
`define CCI_POS_MEM_CH 28
`define CCI_POS_F6_SIZE 16
`define CCI_POS_PARALLEL 1

// ***********************************************************************
// reset values
// ***********************************************************************
`define CCI_RDATA_RST 32'h0000_0000
`define CCI_HIT_RST 1'b0

`endif

// file: cci_pkg.sv
// Purpose: types shared by the inquiry bank modules
// Assumes: cci_map.svh supplies the address width
// Notes: request and answer travel as packed structs
`include "cci_map.svh"

package cci_pkg;

    // ***********************************************************************
    // handshake carriers
    // ***********************************************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [`CCI_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } cci_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [31:0] data;
    } cci_rsp_t;

    // ***********************************************************************
    // decode and state
    // ***********************************************************************
    typedef enum logic [3:0] {
        CCI_SEL_NONE = 4'h0,
        CCI_SEL_BASIC = 4'h1,
        CCI_SEL_FEAT_HI = 4'h2,
        CCI_SEL_FEAT_LO = 4'h3,
        CCI_SEL_OPT = 4'h4,
        CCI_SEL_VENDOR = 4'h5,
        CCI_SEL_PIO = 4'h6,
        CCI_SEL_SIO = 4'h7,
        CCI_SEL_FLASH = 4'h8
    } cci_sel_t;

    typedef enum logic [0:0] {
        CCI_ST_IDLE = 1'b0,
        CCI_ST_ANSWER = 1'b1
    } cci_state_t;

    typedef struct packed {
        cci_state_t state;
        logic hit;
        logic [31:0] rdata;
    } cci_regs_t;

endpackage

// file: cci_addr_decode.sv
// Purpose: map a byte offset onto one inquiry word
// Assumes: offsets are within the initial register space
// Notes: misaligned offsets select nothing
`timescale 1ns/1ps
`default_nettype none
`include "cci_map.svh"

module cci_addr_decode (
    input wire logic [`CCI_ADDR_W-1:0] addr,
    output cci_pkg::cci_sel_t sel,
    output logic gap
);

    // ***********************************************************************
    // decode
    // ***********************************************************************
    // a partial quadlet never matches a word, so it reads as zero
    always_comb begin
        sel = cci_pkg::CCI_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr)
                `CCI_OFF_BASIC: sel = cci_pkg::CCI_SEL_BASIC;
                `CCI_OFF_FEAT_HI: sel = cci_pkg::CCI_SEL_FEAT_HI;
                `CCI_OFF_FEAT_LO: sel = cci_pkg::CCI_SEL_FEAT_LO;
                `CCI_OFF_OPT: sel = cci_pkg::CCI_SEL_OPT;
                `CCI_OFF_VENDOR_PTR: sel = cci_pkg::CCI_SEL_VENDOR;
                `CCI_OFF_PIO_PTR: sel = cci_pkg::CCI_SEL_PIO;
                `CCI_OFF_SIO_PTR: sel = cci_pkg::CCI_SEL_SIO;
                `CCI_OFF_FLASH_PTR: sel = cci_pkg::CCI_SEL_FLASH;
                default: sel = cci_pkg::CCI_SEL_NONE;
            endcase
        end
    end

    // reserved window between the optional word and the vendor pointer
    assign gap = (addr >= `CCI_OFF_GAP_LO) && (addr <= `CCI_OFF_GAP_HI);

endmodule
`default_nettype wire

// file: cci_quadlet_pack.sv
// Purpose: turn msb-first flag vectors into quadlets
// Assumes: input index i is field position i
// Notes: one instance serves every flag word
`timescale 1ns/1ps
`default_nettype none

module cci_quadlet_pack #(
    parameter int N_WORDS = 4
) (
    input wire logic [N_WORDS*32-1:0] pos_bits,
    output logic [N_WORDS*32-1:0] quadlets
);

    // ***********************************************************************
    // bit reversal per word
    // ***********************************************************************
    // position 0 lands on the quadlet msb
    for (genvar w = 0; w < N_WORDS; w++) begin : g_word
        for (genvar b = 0; b < 32; b++) begin : g_bit
            assign quadlets[w*32 + 31 - b] = pos_bits[w*32 + b];
        end
    end

endmodule
`default_nettype wire

// file: cci_host_model.sv
// Purpose: host side model issuing quadlet reads and writes to the bank
// Assumes: valid/ready request port, answer stands right after the taking edge
// Notes: released request lines show inverted last values, never zeros
`timescale 1ns/1ps
`default_nettype none

module cci_host_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_ready,
    input wire cci_pkg::cci_rsp_t rsp,
    output var cci_pkg::cci_req_t req
);

    // ***********************************************************************
    // request driver
    // ***********************************************************************

    // idle at time zero
    initial begin
        req = '0;
    end

    // one quadlet access; chain leaves the lines for the next call to load
    task automatic access(
        input logic [11:0] addr,
        input logic wr,
        input logic [31:0] wdata,
        input int lag,
        input logic chain,
        output logic ans_valid,
        output logic [31:0] data,
        output logic hit
    );
        int n;
        n = 0;
        // a request raised during reset would be thrown away
        while (rst !== 1'b0) begin
            @(posedge ref_clk);
            #1;
        end
        // a slow host idles a few cycles before asking
        if (lag > 0) begin
            repeat (lag) @(posedge ref_clk);
            #1;
        end
        req = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
        // ready follows state only, so it has settled one ns past the edge
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        // the next edge takes the request; the answer stands after it
        @(posedge ref_clk);
        #1;
        ans_valid = rsp.valid;
        data = rsp.data;
        hit = rsp.hit;
        // released lines must not look like a stale request
        if (!chain) begin
            req = '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
            // an edge passes so the next call never reloads in this step
            @(posedge ref_clk);
            #1;
        end
    endtask

endmodule
`default_nettype wire

// file: test_camera_capability_inquiry_regs.sv
// Purpose: self-checking bench for the capability inquiry bank
// Assumes: host model drives requests one ns after the rising edge
// Notes: expectations built from field positions, msb-first numbering
`timescale 1ns/1ps
`default_nettype none
`include "cci_map.svh"

module test_camera_capability_inquiry_regs;

    // ***********************************************************************
    // build-time capabilities, chosen asymmetric so bit reversal shows
    // ***********************************************************************
    localparam logic [15:0] P_HI = 16'h4a53;
    localparam logic [3:0] P_PTZ = 4'hb;
    localparam logic [1:0] P_F6 = 2'h1;
    localparam logic [3:0] P_MEM = 4'hd;
    localparam logic [31:0] P_VEND = 32'h000f_0000;
    localparam logic [31:0] P_PIO = 32'h000f_1100;
    localparam logic [31:0] P_SIO = 32'h000f_1200;
    localparam logic [31:0] P_FLASH = 32'h000f_1300;
    localparam logic P_ADV = 1'b1;
    localparam logic P_VMODE = 1'b0;
    localparam logic P_FERR = 1'b1;
    localparam logic P_BMODE = 1'b1;
    localparam logic P_POWER = 1'b0;
    localparam logic P_ONE = 1'b1;
    localparam logic P_MULTI = 1'b0;
    localparam logic P_PAR = 1'b0;
    localparam logic P_SER = 1'b1;
    localparam logic P_FLASH_CAP = 1'b0;

    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic [31:0] exp_d;
        logic exp_h;
    } cci_row_t;

    logic ref_clk;
    logic rst;
    logic req_ready;
    cci_pkg::cci_req_t req;
    cci_pkg::cci_rsp_t rsp;
    int n_errors = 0;
    int n_checks = 0;
    logic [31:0] e_basic, e_hi, e_lo, e_opt;
    cci_row_t rows[14];

    // ***********************************************************************
    // clock, design and host
    // ***********************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    cci_inquiry_regs #(
        .ADV_FEATURE_CAP(P_ADV), .VMODE_ERR_CAP(P_VMODE),
        .FEAT_ERR_CAP(P_FERR), .B_MODE_CAP(P_BMODE), .POWER_CAP(P_POWER),
        .ONE_SHOT_CAP(P_ONE), .MULTI_SHOT_CAP(P_MULTI),
        .MAX_MEM_CHANNEL(P_MEM),
        .FEAT_HI_CAPS(P_HI), .FEAT_LO_PTZ_CAPS(P_PTZ),
        .FEAT_LO_F6_CAPS(P_F6), .PARALLEL_IO_CAP(P_PAR),
        .SERIAL_IO_CAP(P_SER), .FLASH_OUT_CAP(P_FLASH_CAP),
        .VENDOR_PTR(P_VEND),
        .PARALLEL_IO_PTR(P_PIO), .SERIAL_IO_PTR(P_SIO),
        .FLASH_OUT_PTR(P_FLASH)
    ) cci_inquiry_regs_inst (
        .ref_clk(ref_clk), .rst(rst), .req(req), .req_ready(req_ready),
        .rsp(rsp)
    );

    cci_host_model cci_host_model_inst (
        .ref_clk(ref_clk), .rst(rst), .req_ready(req_ready), .rsp(rsp),
        .req(req)
    );

    // ***********************************************************************
    // helpers
    // ***********************************************************************

    // position p counts from the quadlet msb
    function automatic logic [31:0] fld(input logic v, input int p);
        fld = v ? (32'h8000_0000 >> p) : 32'h0000_0000;
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one access; write data all ones so a stored write would show
    task automatic xfer(input cci_row_t r, input int lag, input logic chain);
        logic v;
        logic h;
        logic [31:0] d;
        cci_host_model_inst.access(r.addr, r.wr, 32'hffff_ffff, lag, chain,
                                   v, d, h);
        check("answer valid", {31'h0, v}, 32'h1);
        check("answer data", d, r.exp_d);
        check("answer hit", {31'h0, h}, {31'h0, r.exp_h});
    endtask

    task automatic idle_outputs(input string what);
        check({what, " valid"}, {31'h0, rsp.valid}, 32'h0);
        check({what, " ready"}, {31'h0, req_ready}, 32'h1);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog far beyond the few dozen cycles the run needs
    initial begin
        #20000;
        n_errors++;
        $display("test watchdog expired");
        give_verdict();
    end

    // ***********************************************************************
    // main sequence
    // ***********************************************************************
    initial begin
        rst = 1'b1;
        e_basic = fld(P_ADV, 0) | fld(P_VMODE, 1) | fld(P_FERR, 2)
                | fld(P_PAR | P_SER | P_FLASH_CAP, 3) | fld(P_BMODE, 8)
                | fld(P_POWER, 16) | fld(P_ONE, 19) | fld(P_MULTI, 20)
                | {28'h0, P_MEM};
        e_hi = 32'h0;
        e_lo = fld(P_F6[0], 16) | fld(P_F6[1], 17);
        for (int i = 0; i < 16; i++) begin
            e_hi = e_hi | fld(P_HI[i], i);
        end
        for (int i = 0; i < 4; i++) begin
            e_lo = e_lo | fld(P_PTZ[i], i);
        end
        e_opt = fld(P_PAR, 1) | fld(P_SER, 2) | fld(P_FLASH_CAP, 3);
        rows[0] = '{`CCI_OFF_BASIC, 1'b0, e_basic, 1'b1};
        rows[1] = '{`CCI_OFF_FEAT_HI, 1'b0, e_hi, 1'b1};
        rows[2] = '{`CCI_OFF_FEAT_LO, 1'b0, e_lo, 1'b1};
        rows[3] = '{`CCI_OFF_OPT, 1'b0, e_opt, 1'b1};
        rows[4] = '{`CCI_OFF_VENDOR_PTR, 1'b0, P_VEND, 1'b1};
        rows[5] = '{`CCI_OFF_PIO_PTR, 1'b0, P_PIO, 1'b1};
        rows[6] = '{`CCI_OFF_SIO_PTR, 1'b0, P_SIO, 1'b1};
        rows[7] = '{`CCI_OFF_FLASH_PTR, 1'b0, P_FLASH, 1'b1};
        rows[8] = '{`CCI_OFF_GAP_LO, 1'b0, 32'h0, 1'b1};
        rows[9] = '{`CCI_OFF_GAP_HI, 1'b0, 32'h0, 1'b1};
        rows[10] = '{12'h402, 1'b0, 32'h0, 1'b0};
        rows[11] = '{12'h490, 1'b0, 32'h0, 1'b0};
        rows[12] = '{12'h3fc, 1'b0, 32'h0, 1'b0};
        rows[13] = '{`CCI_OFF_BASIC, 1'b1, 32'h0, 1'b1};
        // outputs during reset
        repeat (2) @(posedge ref_clk);
        #1;
        idle_outputs("reset");
        check("reset data", rsp.data, 32'h0);
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        @(posedge ref_clk);
        #1;
        $display("test reset values done");
        foreach (rows[i]) begin
            xfer(rows[i], 0, 1'b0);
        end
        $display("test table done");
        // back-to-back, a write in between, then the pulse must end
        xfer(rows[0], 0, 1'b1);
        xfer(rows[7], 0, 1'b1);
        xfer('{`CCI_OFF_FEAT_HI, 1'b1, 32'h0, 1'b1}, 0, 1'b1);
        xfer(rows[1], 0, 1'b0);
        @(posedge ref_clk);
        #1;
        idle_outputs("after burst");
        $display("test back to back done");
        // slow host
        xfer(rows[3], 3, 1'b0);
        $display("test slow host done");
        // reset in mid-run clears the held answer
        xfer(rows[0], 0, 1'b0);
        rst = 1'b1;
        @(posedge ref_clk);
        #1;
        idle_outputs("mid reset");
        check("mid reset data", rsp.data, 32'h0);
        check("mid reset hit", {31'h0, rsp.hit}, 32'h0);
        rst = 1'b0;
        @(posedge ref_clk);
        #1;
        xfer(rows[1], 0, 1'b0);
        $display("test mid reset done");
        give_verdict();
    end

endmodule
`default_nettype wire
